// file: hw/hsf_defs.svh
`ifndef HSF_DEFS_SVH
`define HSF_DEFS_SVH
`define HSF_DW 16
`define HSF_CW 5
`define HSF_MA_DEPTH 16
`define HSF_MA_AW 4
`define HSF_CNT_MIN 5'h01
`define HSF_CNT_MAX 5'h10
`define HSF_R_SCALE 32'h0000_0064
`define HSF_P_SHIFT 10
`define HSF_RATE_SCALE 34'sh0_0000_03E8
`define HSF_RATE_MIN 16'shFC18
`define HSF_REF_RATE_MAX 16'sh270F
`define HSF_LAST_RATE_MAX 16'sh07D0
`define HSF_SAT16 16'hFFFF
`define HSF_RST_DATA 16'h0000
`define HSF_RST_CNT 5'h00
`define HSF_RST_IDX 4'h0
`define HSF_RST_ABSENT 1'b1
`endif

// file: hw/hsf_pkg.sv
`include "hsf_defs.svh"
package hsf_pkg;
	typedef enum logic [0:0] {HSF_WAIT = 1'b0, HSF_SETTLED_INDICATOR = 1'b1} hsf_state_t;
	typedef enum logic [0:0] {HSF_MODE_POWER = 1'b0, HSF_MODE_TEMP = 1'b1} hsf_mode_t;

	// Averaging count limited to 1..depth
	function automatic logic [`HSF_CW-1:0] hsf_clamp_cnt(input logic [`HSF_CW-1:0] code);
		if (code < `HSF_CNT_MIN)
			return `HSF_CNT_MIN;
		else if (code > `HSF_CNT_MAX)
			return `HSF_CNT_MAX;
		return code;
	endfunction : hsf_clamp_cnt
endpackage : hsf_pkg

// file: hw/hsf_moving_avg.sv
`timescale 1ns/100ps
`default_nettype none
`include "hsf_defs.svh"
module hsf_moving_avg (
	input wire logic clk,
	input wire logic rst,
	input wire logic sample_valid,
	input wire logic [`HSF_DW-1:0] sample,
	input wire logic [`HSF_CW-1:0] avg_count,
	output logic [`HSF_DW-1:0] avg,
	output logic avg_valid
);
	logic [`HSF_DW-1:0] mem [`HSF_MA_DEPTH];
	logic [`HSF_DW-1:0] next_mem [`HSF_MA_DEPTH];
	logic [`HSF_MA_AW-1:0] wr_idx, next_wr_idx;
	logic [`HSF_CW-1:0] fill, next_fill;
	logic [`HSF_DW-1:0] next_avg;
	logic next_avg_valid;
	logic [`HSF_CW-1:0] eff, used;
	logic [`HSF_DW+`HSF_CW-1:0] sum;

	// Mean of new sample and the newest stored ones
	always_comb begin
		eff = hsf_pkg::hsf_clamp_cnt(avg_count);
		used = (fill < eff) ? fill + `HSF_CNT_MIN : eff;
		sum = {`HSF_RST_CNT, sample};
		for (int k = 1; k < `HSF_MA_DEPTH; k++) begin
			if (`HSF_CW'(k) < used)
				sum = sum + {`HSF_RST_CNT, mem[wr_idx - `HSF_MA_AW'(k)]};
		end
		next_mem = mem;
		next_wr_idx = wr_idx;
		next_fill = fill;
		next_avg = avg;
		next_avg_valid = 1'b0;
		if (sample_valid) begin
			next_mem[wr_idx] = sample;
			next_wr_idx = wr_idx + `HSF_MA_AW'(1);
			next_fill = (fill < `HSF_CNT_MAX) ? fill + `HSF_CNT_MIN : fill;
			next_avg = `HSF_DW'(sum / {`HSF_RST_DATA, used});
			next_avg_valid = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < `HSF_MA_DEPTH; i++)
				mem[i] <= `HSF_RST_DATA;
			wr_idx <= `HSF_RST_IDX;
			fill <= `HSF_RST_CNT;
			avg <= `HSF_RST_DATA;
			avg_valid <= 1'b0;
		end else begin
			mem <= next_mem;
			wr_idx <= next_wr_idx;
			fill <= next_fill;
			avg <= next_avg;
			avg_valid <= next_avg_valid;
		end
	end
endmodule : hsf_moving_avg
`default_nettype wire

// file: hw/hsf_stabilizer.sv
// Overview of operation
// - Two operating steps only: waiting for stabilization and stabilized.
// - Settled indicator is on exactly while stabilized.
// - No deterioration alarm evaluation while waiting for stabilization.
// - Deterioration alarm compares reference change rate against warning and critical levels.
// - Resistance at entry to stabilized becomes the reference resistance.
// - Resistance and power from voltage and current; both change rates derived.
// - Rapid-change alarm follows the last change rate, apart from deterioration.
// - Enter stabilized only when all four conditions hold and no error.
// - Power mode: power in range for the larger averaging count.
// - Temperature mode: temperature in range for resistance averaging count cycles.
// - Resistance deviation within band for the mode's required count.
// - Voltage condition met when voltage is at or above its limit.
// - Current condition met when current is at or above its limit.
// - Any one exit condition returns the block to waiting.
// - Voltage below its lower limit is an exit condition.
// - Current below its lower limit is an exit condition.
// - A measurement error forces waiting regardless of other conditions.
// - Input-absent indicator lit while voltage or current is missing.
// - Resistance and power are moving-averaged over their counts.
`timescale 1ns/100ps
`default_nettype none
`include "hsf_defs.svh"
module hsf_stabilizer (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic CALC_STROBE,
	input wire logic [`HSF_DW-1:0] VOLTAGE,
	input wire logic [`HSF_DW-1:0] CURRENT,
	input wire logic MEAS_ERR,
	input wire logic DISC_MODE,
	input wire logic [`HSF_CW-1:0] PWR_AVG_CNT,
	input wire logic [`HSF_CW-1:0] RES_AVG_CNT,
	input wire logic [`HSF_DW-1:0] VOLT_LOWER,
	input wire logic [`HSF_DW-1:0] CURR_LOWER,
	input wire logic [`HSF_DW-1:0] PWR_SETTLED_INDICATOR_LO,
	input wire logic [`HSF_DW-1:0] PWR_SETTLED_INDICATOR_HI,
	input wire logic signed [`HSF_DW-1:0] TEMP_SETTLED_INDICATOR_LO,
	input wire logic signed [`HSF_DW-1:0] TEMP_SETTLED_INDICATOR_HI,
	input wire logic TEMP_WR,
	input wire logic signed [`HSF_DW-1:0] TEMP_DATA,
	input wire logic [`HSF_DW-1:0] NORM_DEV,
	input wire logic signed [`HSF_DW-1:0] WARN_LEVEL,
	input wire logic signed [`HSF_DW-1:0] CRIT_LEVEL,
	input wire logic [`HSF_DW-1:0] RAPID_LEVEL,
	output logic SETTLED_INDICATOR,
	output logic INPUT_ABSENT,
	output logic DETER_WARN,
	output logic DETER_CRIT,
	output logic RAPID_ALARM,
	output logic [`HSF_DW-1:0] RESISTANCE,
	output logic [`HSF_DW-1:0] POWER,
	output logic signed [`HSF_DW-1:0] TEMPERATURE,
	output logic signed [`HSF_DW-1:0] REF_RATE,
	output logic signed [`HSF_DW-1:0] LAST_RATE,
	output logic CALC_DONE
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (SYS_RST);

	//--------------------------------------------------------------
	// Helpers
	//--------------------------------------------------------------
	function automatic logic [`HSF_DW-1:0] sat16(input logic [31:0] x);
		sat16 = (x[31:16] != `HSF_RST_DATA) ? `HSF_SAT16 : x[15:0];
	endfunction : sat16

	// Change rate in 0.1 % steps, clamped to [-100.0 %, hi]
	function automatic logic signed [`HSF_DW-1:0] rate_of(input logic [`HSF_DW-1:0] val,
			input logic [`HSF_DW-1:0] base, input logic signed [`HSF_DW-1:0] hi);
		logic signed [33:0] q;
		q = '0;
		if (base != `HSF_RST_DATA)
			q = (($signed({{18{1'b0}}, val}) - $signed({{18{1'b0}}, base})) * `HSF_RATE_SCALE)
				/ $signed({{18{1'b0}}, base});
		if (q > hi)
			rate_of = hi;
		else if (q < `HSF_RATE_MIN)
			rate_of = `HSF_RATE_MIN;
		else
			rate_of = q[15:0];
	endfunction : rate_of

	function automatic logic [`HSF_DW:0] mag_of(input logic signed [`HSF_DW-1:0] x);
		mag_of = x[15] ? (`HSF_DW+1)'(-$signed({x[15], x})) : {1'b0, x};
	endfunction : mag_of

	//--------------------------------------------------------------
	// Sampling and averaging
	//--------------------------------------------------------------
	logic [`HSF_DW-1:0] raw_res, raw_pwr, v_q, i_q, next_v_q, next_i_q;
	logic [`HSF_DW-1:0] r_avg, p_avg;
	logic eval;
	logic [31:0] res_num;

	always_comb begin
		res_num = {`HSF_RST_DATA, VOLTAGE} * `HSF_R_SCALE;
		raw_res = (CURRENT == `HSF_RST_DATA) ? `HSF_SAT16 : sat16(res_num / {`HSF_RST_DATA, CURRENT});
		raw_pwr = sat16(({`HSF_RST_DATA, VOLTAGE} * {`HSF_RST_DATA, CURRENT}) >> `HSF_P_SHIFT);
		next_v_q = CALC_STROBE ? VOLTAGE : v_q;
		next_i_q = CALC_STROBE ? CURRENT : i_q;
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			v_q <= `HSF_RST_DATA;
			i_q <= `HSF_RST_DATA;
		end else begin
			v_q <= next_v_q;
			i_q <= next_i_q;
		end
	end

	// Averaged values land one cycle after the strobe
	hsf_moving_avg u_res_avg (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.sample_valid(CALC_STROBE),
		.sample(raw_res),
		.avg_count(RES_AVG_CNT),
		.avg(r_avg),
		.avg_valid(eval)
	);

	hsf_moving_avg u_pwr_avg (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.sample_valid(CALC_STROBE),
		.sample(raw_pwr),
		.avg_count(PWR_AVG_CNT),
		.avg(p_avg),
		.avg_valid()
	);

	//--------------------------------------------------------------
	// Host temperature
	//--------------------------------------------------------------
	logic signed [`HSF_DW-1:0] temp, next_temp;

	always_comb begin
		next_temp = TEMP_WR ? TEMP_DATA : temp;
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			temp <= `HSF_RST_DATA;
		else
			temp <= next_temp;
	end

	//--------------------------------------------------------------
	// Condition run counters
	//--------------------------------------------------------------
	logic temp_mode, volt_ok, cur_ok, pwr_in, temp_in, c1_in, dev_in, norm_ok, next_norm_ok;
	logic [`HSF_CW-1:0] rc, pc, need, c1_cnt, next_c1_cnt, res_cnt, next_res_cnt;
	logic [`HSF_DW-1:0] norm_ref, next_norm_ref;
	logic signed [`HSF_DW-1:0] dev;

	always_comb begin
		temp_mode = (DISC_MODE == hsf_pkg::HSF_MODE_TEMP);
		rc = hsf_pkg::hsf_clamp_cnt(RES_AVG_CNT);
		pc = hsf_pkg::hsf_clamp_cnt(PWR_AVG_CNT);
		// Same count serves both run conditions in either mode
		need = (temp_mode || rc >= pc) ? rc : pc;
		volt_ok = (v_q >= VOLT_LOWER);
		cur_ok = (i_q >= CURR_LOWER);
		pwr_in = (p_avg >= PWR_SETTLED_INDICATOR_LO) && (p_avg <= PWR_SETTLED_INDICATOR_HI);
		temp_in = (temp >= TEMP_SETTLED_INDICATOR_LO) && (temp <= TEMP_SETTLED_INDICATOR_HI);
		c1_in = temp_mode ? temp_in : pwr_in;
		dev = rate_of(r_avg, norm_ref, `HSF_REF_RATE_MAX);
		dev_in = norm_ok && (mag_of(dev) <= {1'b0, NORM_DEV});
		next_c1_cnt = c1_cnt;
		next_res_cnt = res_cnt;
		next_norm_ref = norm_ref;
		next_norm_ok = norm_ok;
		if (MEAS_ERR) begin
			next_c1_cnt = `HSF_RST_CNT;
			next_res_cnt = `HSF_RST_CNT;
			next_norm_ok = 1'b0;
		end else if (eval) begin
			if (!c1_in)
				next_c1_cnt = `HSF_RST_CNT;
			else if (c1_cnt < `HSF_CNT_MAX)
				next_c1_cnt = c1_cnt + `HSF_CNT_MIN;
			if (!dev_in) begin
				// Restart the band around the present resistance
				next_res_cnt = `HSF_RST_CNT;
				next_norm_ref = r_avg;
				next_norm_ok = 1'b1;
			end else if (res_cnt < `HSF_CNT_MAX) begin
				next_res_cnt = res_cnt + `HSF_CNT_MIN;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			c1_cnt <= `HSF_RST_CNT;
			res_cnt <= `HSF_RST_CNT;
			norm_ref <= `HSF_RST_DATA;
			norm_ok <= 1'b0;
		end else begin
			c1_cnt <= next_c1_cnt;
			res_cnt <= next_res_cnt;
			norm_ref <= next_norm_ref;
			norm_ok <= next_norm_ok;
		end
	end

	//--------------------------------------------------------------
	// Resistance history for the last change rate
	//--------------------------------------------------------------
	logic [`HSF_DW-1:0] hist [`HSF_MA_DEPTH];
	logic [`HSF_DW-1:0] next_hist [`HSF_MA_DEPTH];
	logic [`HSF_MA_AW-1:0] hidx, next_hidx;
	logic [`HSF_CW-1:0] hfill, next_hfill;
	logic [`HSF_DW-1:0] hist_old;

	always_comb begin
		hist_old = hist[hidx - rc[`HSF_MA_AW-1:0]];
		next_hist = hist;
		next_hidx = hidx;
		next_hfill = hfill;
		if (eval) begin
			next_hist[hidx] = r_avg;
			next_hidx = hidx + `HSF_MA_AW'(1);
			next_hfill = (hfill < `HSF_CNT_MAX) ? hfill + `HSF_CNT_MIN : hfill;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			for (int i = 0; i < `HSF_MA_DEPTH; i++)
				hist[i] <= `HSF_RST_DATA;
			hidx <= `HSF_RST_IDX;
			hfill <= `HSF_RST_CNT;
		end else begin
			hist <= next_hist;
			hidx <= next_hidx;
			hfill <= next_hfill;
		end
	end

	//--------------------------------------------------------------
	// Step control and alarms
	//--------------------------------------------------------------
	hsf_pkg::hsf_state_t state, next_state;
	logic enter, leave, ref_ok, next_ref_ok;
	logic next_absent, next_warn, next_crit, next_rapid;
	logic [`HSF_DW-1:0] ref_res, next_ref_res;
	logic signed [`HSF_DW-1:0] next_ref_rate, next_last_rate;

	always_comb begin
		enter = (next_c1_cnt >= need) && (next_res_cnt >= need) && volt_ok && cur_ok;
		leave = !c1_in || !dev_in || !volt_ok || !cur_ok;
		next_state = state;
		next_ref_res = ref_res;
		next_ref_ok = ref_ok;
		unique case (state)
			hsf_pkg::HSF_WAIT: begin
				if (eval && !MEAS_ERR && enter) begin
					next_state = hsf_pkg::HSF_SETTLED_INDICATOR;
					next_ref_res = r_avg;
					next_ref_ok = 1'b1;
				end
			end
			hsf_pkg::HSF_SETTLED_INDICATOR: begin
				if (MEAS_ERR)
					next_state = hsf_pkg::HSF_WAIT;
				else if (eval && leave)
					next_state = hsf_pkg::HSF_WAIT;
			end
		endcase
		next_ref_rate = REF_RATE;
		next_last_rate = LAST_RATE;
		next_absent = INPUT_ABSENT;
		next_rapid = RAPID_ALARM;
		next_warn = DETER_WARN;
		next_crit = DETER_CRIT;
		if (eval) begin
			next_ref_rate = next_ref_ok ? rate_of(r_avg, next_ref_res, `HSF_REF_RATE_MAX) : `HSF_RST_DATA;
			next_last_rate = (hfill >= rc) ? rate_of(r_avg, hist_old, `HSF_LAST_RATE_MAX) : `HSF_RST_DATA;
			next_absent = !(volt_ok && cur_ok);
			next_rapid = mag_of(next_last_rate) > {1'b0, RAPID_LEVEL};
			if (state == hsf_pkg::HSF_SETTLED_INDICATOR) begin
				next_warn = next_ref_rate > WARN_LEVEL;
				next_crit = next_ref_rate > CRIT_LEVEL;
			end
		end
		if (next_state == hsf_pkg::HSF_WAIT) begin
			next_warn = 1'b0;
			next_crit = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state <= hsf_pkg::HSF_WAIT;
			ref_res <= `HSF_RST_DATA;
			ref_ok <= 1'b0;
			REF_RATE <= `HSF_RST_DATA;
			LAST_RATE <= `HSF_RST_DATA;
			INPUT_ABSENT <= `HSF_RST_ABSENT;
			RAPID_ALARM <= 1'b0;
			DETER_WARN <= 1'b0;
			DETER_CRIT <= 1'b0;
			CALC_DONE <= 1'b0;
		end else begin
			state <= next_state;
			ref_res <= next_ref_res;
			ref_ok <= next_ref_ok;
			REF_RATE <= next_ref_rate;
			LAST_RATE <= next_last_rate;
			INPUT_ABSENT <= next_absent;
			RAPID_ALARM <= next_rapid;
			DETER_WARN <= next_warn;
			DETER_CRIT <= next_crit;
			CALC_DONE <= eval;
		end
	end

	assign SETTLED_INDICATOR = (state == hsf_pkg::HSF_SETTLED_INDICATOR);
	assign RESISTANCE = r_avg;
	assign POWER = p_avg;
	assign TEMPERATURE = temp;

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	a_err_forces_wait: assert property (MEAS_ERR |=> !SETTLED_INDICATOR)
		else $error("Measurement error did not force waiting");
	a_entry_on_eval: assert property ($rose(SETTLED_INDICATOR) |-> $past(eval) && !$past(MEAS_ERR))
		else $error("Stabilized entered outside a clean evaluation");
	a_power_run_met: assert property ($rose(SETTLED_INDICATOR) && !$past(temp_mode)
		|-> c1_cnt >= $past(pc) && c1_cnt >= $past(rc))
		else $error("Power run shorter than larger averaging count");
	a_temp_run_met: assert property ($rose(SETTLED_INDICATOR) && $past(temp_mode) |-> c1_cnt >= $past(rc))
		else $error("Temperature run shorter than resistance count");
	a_res_run_met: assert property ($rose(SETTLED_INDICATOR) |-> res_cnt >= $past(need) && res_cnt != 5'h00)
		else $error("Resistance run too short at entry");
	a_wait_no_alarm: assert property (!SETTLED_INDICATOR |-> !DETER_WARN && !DETER_CRIT)
		else $error("Deterioration alarm active while waiting");
	a_crit_above: assert property ($rose(DETER_CRIT) |-> REF_RATE > $past(CRIT_LEVEL) && $past(SETTLED_INDICATOR))
		else $error("Critical alarm without rate above level");
	a_volt_exit: assert property (eval && SETTLED_INDICATOR && v_q < VOLT_LOWER |=> !SETTLED_INDICATOR)
		else $error("Low voltage did not exit stabilized");
	a_curr_exit: assert property (eval && SETTLED_INDICATOR && i_q < CURR_LOWER |=> !SETTLED_INDICATOR)
		else $error("Low current did not exit stabilized");
	a_absent_tracks: assert property (eval |=> INPUT_ABSENT == !($past(volt_ok) && $past(cur_ok)))
		else $error("Input-absent indicator wrong after evaluation");
	a_ref_capture: assert property ($rose(SETTLED_INDICATOR) |-> ref_res == $past(RESISTANCE) ##1 ref_ok)
		else $error("Reference resistance not captured at entry");
	a_temp_hold: assert property (!TEMP_WR |=> $stable(TEMPERATURE))
		else $error("Temperature changed without a host write");
	a_band_clear: assert property (eval && !MEAS_ERR && !dev_in |=> res_cnt == 5'h00)
		else $error("Resistance run counter not cleared");

	c_enter_power: cover property ($rose(SETTLED_INDICATOR) && !temp_mode);
	c_enter_temp: cover property ($rose(SETTLED_INDICATOR) && temp_mode);
	c_crit_alarm: cover property ($rose(DETER_CRIT));
	c_volt_exit: cover property ($fell(SETTLED_INDICATOR) && $past(v_q < VOLT_LOWER));
endmodule : hsf_stabilizer
`default_nettype wire

// file: dv/hsf_front_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "hsf_defs.svh"
module hsf_front_end (
	input wire logic clk,
	input wire logic req,
	input wire logic [`HSF_DW-1:0] v_set,
	input wire logic [`HSF_DW-1:0] i_set,
	output var logic strobe,
	output var logic [`HSF_DW-1:0] volt,
	output var logic [`HSF_DW-1:0] curr
);
	initial begin
		strobe = 1'b0;
		volt = 16'h0000;
		curr = 16'h0000;
	end
	// Sample lines only hold during the strobe; otherwise they toggle
	always @(posedge clk) begin
		strobe <= req;
		volt <= req ? v_set : ~volt;
		curr <= req ? i_set : ~curr;
	end
endmodule : hsf_front_end
`default_nettype wire

// file: dv/test_heater_stabilization_fsm.sv
`timescale 1ns/100ps
`default_nettype none
`include "hsf_defs.svh"
module test_heater_stabilization_fsm;
	typedef struct {logic [15:0] v; logic [15:0] i; logic [15:0] r; logic [15:0] p; logic a;} hsf_row_t;
	typedef struct {logic m; logic [4:0] pc; logic [4:0] rc; int n; logic [15:0] t; logic e;} hsf_ent_t;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic req = 1'b0;
	logic meas_err = 1'b0;
	logic disc_mode = 1'b0;
	logic temp_wr = 1'b0;
	logic [4:0] pwr_cnt = 5'h01;
	logic [4:0] res_cnt = 5'h01;
	logic [15:0] v_set = 16'h0000;
	logic [15:0] i_set = 16'h0000;
	logic [15:0] v_low = 16'h0064;
	logic [15:0] i_low = 16'h000A;
	logic [15:0] p_lo = 16'h0000;
	logic [15:0] p_hi = 16'h0064;
	logic signed [15:0] t_lo = 16'sh0000;
	logic signed [15:0] t_hi = 16'sh0064;
	logic signed [15:0] temp_data = 16'sh0000;
	logic [15:0] norm_dev = 16'h0064;
	logic signed [15:0] warn_lvl = 16'sh001E;
	logic signed [15:0] crit_lvl = 16'sh0032;
	logic [15:0] rapid_lvl = 16'h000F;
	logic strobe, settled, absent, warn, crit, rapid, done;
	logic [15:0] volt, curr, res, pwr;
	logic signed [15:0] temp, ref_rate, last_rate;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	hsf_row_t rows [5] = '{'{16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 1'b1},
		'{16'h00C8, 16'h0014, 16'h03E8, 16'h0003, 1'b0}, '{16'h0063, 16'h0014, 16'h01EF, 16'h0001, 1'b1},
		'{16'h0064, 16'h0009, 16'h0457, 16'h0000, 1'b1}, '{16'h0064, 16'h000A, 16'h03E8, 16'h0000, 1'b0}};
	hsf_ent_t ents [6] = '{'{1'b0, 5'h01, 5'h01, 1, 16'h0032, 1'b1}, '{1'b0, 5'h03, 5'h02, 3, 16'h0032, 1'b1},
		'{1'b0, 5'h02, 5'h04, 4, 16'h0032, 1'b1}, '{1'b0, 5'h00, 5'h00, 1, 16'h0032, 1'b1},
		'{1'b1, 5'h03, 5'h02, 2, 16'h0032, 1'b1}, '{1'b1, 5'h01, 5'h01, 3, 16'h0065, 1'b0}};
	hsf_front_end u_hsf_front_end (.clk(core_clk), .req(req), .v_set(v_set), .i_set(i_set),
		.strobe(strobe), .volt(volt), .curr(curr));
	hsf_stabilizer u_hsf_stabilizer (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .CALC_STROBE(strobe),
		.VOLTAGE(volt), .CURRENT(curr), .MEAS_ERR(meas_err), .DISC_MODE(disc_mode),
		.PWR_AVG_CNT(pwr_cnt), .RES_AVG_CNT(res_cnt), .VOLT_LOWER(v_low), .CURR_LOWER(i_low),
		.PWR_SETTLED_INDICATOR_LO(p_lo), .PWR_SETTLED_INDICATOR_HI(p_hi), .TEMP_SETTLED_INDICATOR_LO(t_lo), .TEMP_SETTLED_INDICATOR_HI(t_hi),
		.TEMP_WR(temp_wr), .TEMP_DATA(temp_data), .NORM_DEV(norm_dev), .WARN_LEVEL(warn_lvl),
		.CRIT_LEVEL(crit_lvl), .RAPID_LEVEL(rapid_lvl), .SETTLED_INDICATOR(settled),
		.INPUT_ABSENT(absent), .DETER_WARN(warn), .DETER_CRIT(crit), .RAPID_ALARM(rapid),
		.RESISTANCE(res), .POWER(pwr), .TEMPERATURE(temp), .REF_RATE(ref_rate),
		.LAST_RATE(last_rate), .CALC_DONE(done));
	// ----
	// Clock, timeout and helpers
	// ----
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task automatic chk1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk1
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk16
	task automatic do_reset();
		@(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
	endtask : do_reset
	// One calculation cycle; outputs settle with the completion pulse
	task automatic meas(input logic [15:0] v, input logic [15:0] i);
		int n;
		n = 0;
		@(posedge core_clk);
		v_set <= v;
		i_set <= i;
		req <= 1'b1;
		@(posedge core_clk);
		req <= 1'b0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (done !== 1'b1 && n < 10);
		chk1(done, 1'b1);
	endtask : meas
	task automatic write_temp(input logic [15:0] t);
		@(posedge core_clk);
		temp_wr <= 1'b1;
		temp_data <= t;
		@(posedge core_clk);
		temp_wr <= 1'b0;
		#1;
		chk16(temp, t);
	endtask : write_temp
	task automatic alarms(input logic s, input logic w, input logic c);
		chk1(settled, s);
		chk1(warn, w);
		chk1(crit, c);
	endtask : alarms
	// ----
	// Main sequence
	// ----
	initial begin
		do_reset();
		#1;
		alarms(1'b0, 1'b0, 1'b0);
		chk1(absent, 1'b1);
		chk1(done, 1'b0);
		chk16(res, 16'h0000);
		for (int k = 0; k < 5; k++) begin
			meas(rows[k].v, rows[k].i);
			chk16(res, rows[k].r);
			chk16(pwr, rows[k].p);
			chk1(absent, rows[k].a);
		end
		@(posedge core_clk);
		pwr_cnt <= 5'h02;
		res_cnt <= 5'h02;
		meas(16'h00D2, 16'h0014);
		chk16(res, 16'h0401);
		chk16(pwr, 16'h0002);
		$display("measurement rows done");
		for (int k = 0; k < 6; k++) begin
			@(posedge core_clk);
			disc_mode <= ents[k].m;
			pwr_cnt <= ents[k].pc;
			res_cnt <= ents[k].rc;
			do_reset();
			write_temp(ents[k].t);
			for (int j = 1; j <= ents[k].n + 1; j++) begin
				meas(16'h00C8, 16'h0014);
				chk1(settled, (j == ents[k].n + 1) ? ents[k].e : 1'b0);
			end
		end
		$display("entry counts done");
		@(posedge core_clk);
		disc_mode <= 1'b0;
		pwr_cnt <= 5'h01;
		res_cnt <= 5'h01;
		do_reset();
		meas(16'h00C8, 16'h0014);
		meas(16'h00C8, 16'h0014);
		alarms(1'b1, 1'b0, 1'b0);
		chk16(ref_rate, 16'h0000);
		meas(16'h00D2, 16'h0014);
		alarms(1'b1, 1'b1, 1'b0);
		chk16(ref_rate, 16'h0032);
		chk1(rapid, 1'b1);
		meas(16'h00D4, 16'h0014);
		alarms(1'b1, 1'b1, 1'b1);
		chk16(last_rate, 16'h0009);
		chk1(rapid, 1'b0);
		meas(16'h0032, 16'h0014);
		alarms(1'b0, 1'b0, 1'b0);
		chk1(absent, 1'b1);
		meas(16'h00D4, 16'h0014);
		alarms(1'b0, 1'b0, 1'b0);
		chk16(ref_rate, 16'h003C);
		meas(16'h00D4, 16'h0014);
		chk1(settled, 1'b1);
		chk16(ref_rate, 16'h0000);
		meas(16'h00D4, 16'h0009);
		chk1(settled, 1'b0);
		$display("alarm and exit done");
		meas(16'h00C8, 16'h0014);
		meas(16'h00C8, 16'h0014);
		meas(16'h07D0, 16'h00C8);
		chk1(settled, 1'b0);
		chk1(absent, 1'b0);
		meas(16'h00C8, 16'h0014);
		meas(16'h00C8, 16'h0014);
		chk1(settled, 1'b1);
		@(posedge core_clk);
		meas_err <= 1'b1;
		@(posedge core_clk);
		meas_err <= 1'b0;
		#1;
		chk1(settled, 1'b0);
		@(posedge core_clk);
		meas_err <= 1'b1;
		meas(16'h00C8, 16'h0014);
		meas(16'h00C8, 16'h0014);
		meas(16'h00C8, 16'h0014);
		chk1(settled, 1'b0);
		$display("error handling done");
		finish_test();
	end
endmodule : test_heater_stabilization_fsm
`default_nettype wire
